/* rtl/meter_mode_regs.sv */
// operating mode and reactive pulse scaling registers behind the serial port
module meter_mode_regs
  import meter_mode_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic ARST_N_IN,
  // serial port
  input wire logic SCLK_IN,
  input wire logic CS_N_IN,
  input wire logic DIN_IN,
  output logic DOUT_OUT,
  output logic DOUT_OE_N_OUT,
  // datapath controls
  output ctrl_type CTRL_OUT,
  output logic [15:0] NUM_OUT,
  output logic [11:0] DEN_OUT,
  output logic [2:0] REV_POL_OUT,
  output logic SOFT_RST_BUSY_OUT
);
  // ---------------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------------
  logic rst_m_r;
  logic rst_s_r;
  logic rst_n;
  spi_in_type pins;

  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end
  assign rst_n = rst_s_r;

  // serial clock and chip select idle high
  sync_two_ff #(.RST_VAL(1'b1)) u_sync_sclk (.clk_in(CORE_CLK_IN), .rst_n_in(rst_n), .d_in(SCLK_IN),
    .q_out(pins.sclk));
  sync_two_ff #(.RST_VAL(1'b1)) u_sync_cs (.clk_in(CORE_CLK_IN), .rst_n_in(rst_n), .d_in(CS_N_IN),
    .q_out(pins.cs_n));
  sync_two_ff u_sync_din (.clk_in(CORE_CLK_IN), .rst_n_in(rst_n), .d_in(DIN_IN), .q_out(pins.din));

  // ---------------------------------------------------------------------
  // edge detection
  // ---------------------------------------------------------------------
  logic sclk_d_r;
  logic rise;
  logic fall;
  logic active;

  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) sclk_d_r <= 1'b1;
    else sclk_d_r <= pins.sclk;
  end
  assign rise = pins.sclk & ~sclk_d_r;
  assign fall = ~pins.sclk & sclk_d_r;
  assign active = ~pins.cs_n;

  // ---------------------------------------------------------------------
  // serial frame: header byte (bit7 write, bits 6:0 address), then data MSB first
  // ---------------------------------------------------------------------
  spi_state_type state_r;
  spi_state_type state_nxt;
  logic [2:0] hbit_r;
  logic [4:0] dbit_r;
  logic [7:0] hdr_r;
  logic [15:0] shin_r;
  logic [15:0] shout_r;
  logic soft_busy_r;
  logic [CNT_W-1:0] busy_cnt_r;
  logic is_write;
  logic [6:0] addr;
  logic [4:0] dlen;
  logic [15:0] rd_data;
  logic hdr_last;
  logic data_last;
  logic wr_strobe;
  logic rd_strobe;

  assign is_write = hdr_r[7];
  assign addr = hdr_r[6:0];
  assign hdr_last = (state_r == ST_ADDR) && rise && (hbit_r == 3'h7);
  assign data_last = (state_r == ST_DATA) && rise && (dbit_r == dlen - 5'h01);
  assign wr_strobe = data_last && is_write;
  assign rd_strobe = hdr_last && !hdr_r[6];

  // access width by address; unmapped reads return zero, unmapped writes ignored
  logic [6:0] next_addr;
  assign next_addr = {hdr_r[5:0], pins.din};
  assign dlen = (addr == ADDR_NUM) ? 5'd16 : (addr == ADDR_DEN) ? 5'd16 : 5'd8;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (active && !soft_busy_r) state_nxt = ST_ADDR;
      ST_ADDR: if (hdr_last) state_nxt = ST_DATA;
      ST_DATA: if (data_last) state_nxt = ST_DONE;
      ST_DONE: state_nxt = ST_DONE;
      default: state_nxt = ST_IDLE;
    endcase
    if (!active) state_nxt = ST_IDLE;
  end

  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) state_r <= ST_IDLE;
    else state_r <= state_nxt;
  end

  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      hbit_r <= 3'h0;
      dbit_r <= 5'h00;
      hdr_r <= 8'h00;
      shin_r <= 16'h0000;
    end else if (state_r == ST_IDLE) begin
      hbit_r <= 3'h0;
      dbit_r <= 5'h00;
    end else if (rise && state_r == ST_ADDR) begin
      hdr_r <= {hdr_r[6:0], pins.din};
      hbit_r <= hbit_r + 3'h1;
    end else if (rise && state_r == ST_DATA) begin
      shin_r <= {shin_r[14:0], pins.din};
      dbit_r <= dbit_r + 5'h01;
    end
  end

  // ---------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------
  logic [7:0] operating_mode_control_r;
  logic [15:0] num_r;
  logic [11:0] den_r;
  logic [7:0] ones_r;
  logic [15:0] wdata;
  logic soft_rst;

  assign wdata = {shin_r[14:0], pins.din};
  assign soft_rst = wr_strobe && (addr == ADDR_OPERATING_MODE_CONTROL) && wdata[SOFT_RST_BIT];

  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      operating_mode_control_r <= OPERATING_MODE_CONTROL_RST;
      num_r <= NUM_RST;
      den_r <= DEN_RST;
    end else if (soft_rst) begin
      operating_mode_control_r <= OPERATING_MODE_CONTROL_RST;
      num_r <= NUM_RST;
      den_r <= DEN_RST;
    end else if (wr_strobe) begin
      if (addr == ADDR_OPERATING_MODE_CONTROL) operating_mode_control_r <= {1'b0, wdata[6:0] & 7'h3F};
      if (addr == ADDR_NUM) num_r <= wdata;
      if (addr == ADDR_DEN) den_r <= wdata[11:0];
    end
  end

  // read mux and ones count of the word being read
  always_comb begin
    case (next_addr)
      ADDR_OPERATING_MODE_CONTROL: rd_data = {operating_mode_control_r, 8'h00};
      ADDR_NUM: rd_data = num_r;
      ADDR_DEN: rd_data = {4'h0, den_r};
      ADDR_ONES: rd_data = {ones_r, 8'h00};
      ADDR_REV: rd_data = {DIE_REV, 8'h00};
      default: rd_data = 16'h0000;
    endcase
  end
  logic [7:0] ones_nxt;
  always_comb begin
    ones_nxt = 8'h00;
    for (int i = 0; i < 16; i++) ones_nxt = ones_nxt + {7'h00, rd_data[i]};
  end

  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      ones_r <= 8'h00;
      shout_r <= 16'h0000;
    end else if (rd_strobe) begin
      if (next_addr != ADDR_ONES) ones_r <= ones_nxt;
      shout_r <= rd_data;
    end else if (fall && state_r == ST_DATA) begin
      shout_r <= {shout_r[14:0], 1'b0};
    end
  end

  // ---------------------------------------------------------------------
  // soft reset hold-off: frames refused while counting
  // ---------------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      soft_busy_r <= 1'b0;
      busy_cnt_r <= '0;
    end else if (soft_rst) begin
      soft_busy_r <= 1'b1;
      busy_cnt_r <= CNT_W'(SOFT_RST_CYC - 1);
    end else if (soft_busy_r) begin
      if (busy_cnt_r == '0) soft_busy_r <= 1'b0;
      else busy_cnt_r <= busy_cnt_r - 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // decode of mode bits into datapath controls
  // ---------------------------------------------------------------------
  logic [2:0] conv;
  ctrl_type ctrl;
  assign conv = operating_mode_control_r[CONV_LSB +: 3];
  assign ctrl.hp_bypass = operating_mode_control_r[HPF_BIT];
  assign ctrl.lp_bypass = operating_mode_control_r[LPF_BIT];
  assign ctrl.pulse_off = operating_mode_control_r[PULSE_OFF_BIT];
  assign ctrl.i_conv_off = (conv == CONV_I_OFF) || (conv == CONV_I_OFF_RD);
  assign ctrl.v_conv_off = (conv == CONV_V_OFF) || (conv == CONV_V_OFF_RD);
  assign ctrl.route_v_to_i = (conv == CONV_SWAP) || (conv == CONV_V_OFF_RD);
  assign ctrl.route_i_to_v = (conv == CONV_SWAP) || (conv == CONV_I_OFF_RD);
  assign ctrl.sleep = (conv == CONV_SLEEP);
  assign ctrl.power_down = (conv == CONV_PDOWN);

  // ---------------------------------------------------------------------
  // output flops
  // ---------------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      CTRL_OUT <= '0;
      NUM_OUT <= NUM_RST;
      DEN_OUT <= DEN_RST;
      REV_POL_OUT <= 3'h0;
      SOFT_RST_BUSY_OUT <= 1'b0;
      DOUT_OUT <= 1'b0;
      DOUT_OE_N_OUT <= 1'b1;
    end else begin
      CTRL_OUT <= ctrl;
      NUM_OUT <= num_r;
      DEN_OUT <= den_r;
      REV_POL_OUT <= {num_r[NUM_PHA_BIT], num_r[NUM_PHB_BIT], num_r[NUM_PHC_BIT]};
      SOFT_RST_BUSY_OUT <= soft_busy_r;
      DOUT_OUT <= shout_r[15];
      DOUT_OE_N_OUT <= !((state_r == ST_DATA) && !is_write);
    end
  end
endmodule

/* inc/meter_mode_pkg.sv */
// constants, types and field layouts of the metering mode register bank
// ---------------------------------------------------------------------
// Overview of operation
// - 16-bit read/write reactive pulse scaling numerator, reset value zero.
// - numerator bits 15,14,13 flag reverse reactive power for phases A,B,C.
// - 12-bit read/write reactive pulse scaling denominator, reset value 3F hex.
// - read-only checksum holds the count of ones in the last register read other than itself.
// - mode bit 0 bypasses current high-pass filters, bit 1 low-pass; both reset zero.
// - mode bit 2, set after reset, disables both pulse-frequency outputs.
// - converter field bits 3 to 5 at zero means normal operation.
// - code 100 swaps voltage and current input routing.
// - code 001 powers off current converters only.
// - code 101 powers off current converters, routes current inputs to voltage paths.
// - code 010 powers off voltage converters only.
// - one code powers off voltage converters, routes voltage inputs to current paths.
// - code 011 puts the whole device to sleep.
// - code 111 puts the device into power-down.
// - writing one to mode bit 6 resets mode, numerator and denominator but not the checksum; host waits 18 us after.
// ---------------------------------------------------------------------
package meter_mode_pkg;
  localparam logic [6:0] ADDR_OPERATING_MODE_CONTROL = 7'h13;
  localparam logic [6:0] ADDR_NUM = 7'h47;
  localparam logic [6:0] ADDR_DEN = 7'h48;
  localparam logic [6:0] ADDR_ONES = 7'h7E;
  localparam logic [6:0] ADDR_REV = 7'h7F;
  localparam logic [7:0] OPERATING_MODE_CONTROL_RST = 8'h04;
  localparam logic [15:0] NUM_RST = 16'h0000;
  localparam logic [11:0] DEN_RST = 12'h03F;
  // die revision value is arbitrary
  localparam logic [7:0] DIE_REV = 8'h01;
  localparam int HPF_BIT = 0;
  localparam int LPF_BIT = 1;
  localparam int PULSE_OFF_BIT = 2;
  localparam int CONV_LSB = 3;
  localparam int SOFT_RST_BIT = 6;
  localparam int NUM_PHA_BIT = 15;
  localparam int NUM_PHB_BIT = 14;
  localparam int NUM_PHC_BIT = 13;
  localparam logic [2:0] CONV_NORMAL = 3'h0;
  localparam logic [2:0] CONV_SWAP = 3'h4;
  localparam logic [2:0] CONV_I_OFF = 3'h1;
  localparam logic [2:0] CONV_I_OFF_RD = 3'h5;
  localparam logic [2:0] CONV_V_OFF = 3'h2;
  localparam logic [2:0] CONV_V_OFF_RD = 3'h6;
  localparam logic [2:0] CONV_SLEEP = 3'h3;
  localparam logic [2:0] CONV_PDOWN = 3'h7;
  // soft reset hold time and its cycle count at 100 MHz
  localparam int SOFT_RST_US = 18;
  localparam int CLK_MHZ = 100;
  localparam int SOFT_RST_CYC = SOFT_RST_US * CLK_MHZ;
  localparam int CNT_W = 11;

  typedef struct packed {
    logic hp_bypass;
    logic lp_bypass;
    logic pulse_off;
    logic i_conv_off;
    logic v_conv_off;
    logic route_v_to_i;
    logic route_i_to_v;
    logic sleep;
    logic power_down;
  } ctrl_type;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic din;
  } spi_in_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_DATA = 4'b0100,
    ST_DONE = 4'b1000
  } spi_state_type;
endpackage

/* rtl/sync_two_ff.sv */
// two-flop synchroniser for one pin input
module sync_two_ff #(
  // reset value matches the pin's idle level, so no false edge follows reset
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic d_in,
  output logic q_out
);
  logic meta_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule

/* verification/meter_mode_regs_properties.sv */
// port-level property checker for the metering mode register bank
module meter_mode_regs_properties
  import meter_mode_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic ARST_N_IN,
  input wire ctrl_type CTRL_OUT,
  input wire logic [15:0] NUM_OUT,
  input wire logic [11:0] DEN_OUT,
  input wire logic [2:0] REV_POL_OUT,
  input wire logic SOFT_RST_BUSY_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  int busy_cnt_r;
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      busy_cnt_r <= 0;
    end else begin
      busy_cnt_r <= SOFT_RST_BUSY_OUT ? busy_cnt_r + 1 : 0;
    end
  end
  sequence rst_gone;
    $rose(ARST_N_IN);
  endsequence
  sequence soft_rst;
    $rose(SOFT_RST_BUSY_OUT);
  endsequence
  polarity_map_a:
    assert property (REV_POL_OUT == NUM_OUT[15:13]) else $error("polarity flags wrong");
  sleep_pdown_excl_a:
    assert property (!(CTRL_OUT.sleep && CTRL_OUT.power_down)) else $error("sleep with power-down");
  i_redirect_a:
    assert property (CTRL_OUT.route_i_to_v && !CTRL_OUT.route_v_to_i |-> CTRL_OUT.i_conv_off && !CTRL_OUT.v_conv_off)
    else $error("current redirect wrong");
  v_redirect_a:
    assert property (CTRL_OUT.route_v_to_i && !CTRL_OUT.route_i_to_v |-> CTRL_OUT.v_conv_off && !CTRL_OUT.i_conv_off)
    else $error("voltage redirect wrong");
  swap_running_a:
    assert property (CTRL_OUT.route_v_to_i && CTRL_OUT.route_i_to_v |-> !CTRL_OUT.i_conv_off && !CTRL_OUT.v_conv_off)
    else $error("swap with converter off");
  reset_values_a:
    assert property (rst_gone |-> NUM_OUT == 16'h0000 && DEN_OUT == 12'h03F) else $error("scaling reset wrong");
  pulse_off_rst_a:
    assert property (rst_gone |-> ##[1:6] CTRL_OUT.pulse_off) else $error("pulse outputs not off");
  soft_restore_a:
    assert property (soft_rst |-> ##[0:4] (NUM_OUT == 16'h0000 && DEN_OUT == 12'h03F && CTRL_OUT.pulse_off))
    else $error("soft reset not restoring");
  soft_hold_a:
    assert property ($fell(SOFT_RST_BUSY_OUT) |-> busy_cnt_r >= SOFT_RST_CYC && busy_cnt_r <= SOFT_RST_CYC + 4)
    else $error("soft reset hold wrong");
endmodule

bind meter_mode_regs meter_mode_regs_properties u_props (.CORE_CLK_IN, .ARST_N_IN, .CTRL_OUT, .NUM_OUT, .DEN_OUT,
  .REV_POL_OUT, .SOFT_RST_BUSY_OUT);

/* verification/spi_host_model.sv */
// host controller model driving the serial port
module spi_host_model
  import meter_mode_pkg::*;
(
  input wire logic clk_in,
  input wire logic dout_in,
  input wire logic dout_oe_n_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic din_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    din_out = 1'b0;
  end
  // half of a 160 ns serial period
  task automatic half();
    repeat (8) @(negedge clk_in);
  endtask
  // one frame, msb first; sclk idles high; device takes bits on rising edges and
  // shifts read data on falling ones, so each read bit is taken just before sclk falls
  task automatic xfer(input logic [7:0] hdr, input logic [15:0] wd, input int n, output logic [15:0] rd);
    logic [23:0] sh;
    sh = {hdr, wd << (16 - n)};
    rd = 16'h0000;
    cs_n_out = 1'b0;
    half();
    for (int i = 0; i < 8 + n; i++) begin
      if (i >= 8) rd = {rd[14:0], dout_oe_n_in ? 1'bx : dout_in};
      sclk_out = 1'b0;
      din_out = sh[23 - i];
      half();
      sclk_out = 1'b1;
      half();
    end
    cs_n_out = 1'b1;
    din_out = ~din_out;
    half();
  endtask
  task automatic wait_soft_reset();
    repeat (SOFT_RST_CYC + 20) @(negedge clk_in);
  endtask
endmodule

/* verification/metering_operating_mode_regs_tb.sv */
// self-checking bench for the metering mode register bank
module metering_operating_mode_regs_tb
  import meter_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0] mode;
    logic [8:0] ctrl;
  } row_type;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic sclk, cs_n, din, dout, dout_oe_n, busy;
  ctrl_type ctrl;
  logic [15:0] num;
  logic [11:0] den;
  logic [2:0] rev_pol;
  int fail_count = 0;
  int n_compared = 0;
  row_type rows [8] = '{'{8'h03, 9'h180}, '{8'h21, 9'h10C}, '{8'h0A, 9'h0A0}, '{8'h2C, 9'h064},
    '{8'h10, 9'h010}, '{8'h30, 9'h018}, '{8'h18, 9'h002}, '{8'h3C, 9'h041}};
  always #5 clk = ~clk;
  meter_mode_regs u_dut (.CORE_CLK_IN(clk), .ARST_N_IN(arst_n), .SCLK_IN(sclk), .CS_N_IN(cs_n), .DIN_IN(din),
    .DOUT_OUT(dout), .DOUT_OE_N_OUT(dout_oe_n), .CTRL_OUT(ctrl), .NUM_OUT(num), .DEN_OUT(den),
    .REV_POL_OUT(rev_pol), .SOFT_RST_BUSY_OUT(busy));
  spi_host_model u_host (.clk_in(clk), .dout_in(dout), .dout_oe_n_in(dout_oe_n), .sclk_out(sclk),
    .cs_n_out(cs_n), .din_out(din));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d, input int n);
    logic [15:0] r;
    u_host.xfer({1'b1, a}, d, n, r);
  endtask
  task automatic rd(input logic [6:0] a, input int n, input logic [15:0] exp, input string what);
    logic [15:0] r;
    u_host.xfer({1'b0, a}, 16'h0000, n, r);
    chk(what, exp, r);
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----------
  // main sequence
  // ----------
  initial begin
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
    chk("ctrl", 16'h0040, 16'(ctrl));
    chk("num", 16'h0000, num);
    chk("den", 16'h003F, {4'h0, den});
    foreach (rows[i]) begin
      wr(ADDR_OPERATING_MODE_CONTROL, {8'h00, rows[i].mode}, 8);
      chk("ctrl", {7'h00, rows[i].ctrl}, {7'h00, ctrl});
      rd(ADDR_OPERATING_MODE_CONTROL, 8, {8'h00, rows[i].mode}, "mode");
      rd(ADDR_ONES, 8, 16'($countones(rows[i].mode)), "ones");
    end
    wr(ADDR_OPERATING_MODE_CONTROL, 16'h0000, 8);
    chk("ctrl", 16'h0000, 16'(ctrl));
    wr(ADDR_NUM, 16'hA5C3, 16);
    chk("num", 16'hA5C3, num);
    chk("polarity", 16'h0005, {13'h0, rev_pol});
    rd(ADDR_NUM, 16, 16'hA5C3, "num");
    rd(ADDR_ONES, 8, 16'h0008, "ones");
    wr(ADDR_DEN, 16'h0ABC, 16);
    rd(ADDR_DEN, 16, 16'h0ABC, "den");
    rd(ADDR_REV, 8, {8'h00, DIE_REV}, "rev");
    wr(ADDR_ONES, 16'h00FF, 8);
    rd(ADDR_ONES, 8, 16'($countones(DIE_REV)), "ones");
    rd(7'h50, 8, 16'h0000, "unmapped");
    wr(ADDR_OPERATING_MODE_CONTROL, 16'h0040, 8);
    chk("busy", 16'h0001, {15'h0, busy});
    chk("den", 16'h003F, {4'h0, den});
    chk("ctrl", 16'h0040, 16'(ctrl));
    u_host.wait_soft_reset();
    chk("busy", 16'h0000, {15'h0, busy});
    wr(ADDR_NUM, 16'hE000, 16);
    chk("polarity", 16'h0007, {13'h0, rev_pol});
    // mid-run reset brings the scaling and mode values back
    @(negedge clk);
    arst_n = 1'b0;
    repeat (3) @(negedge clk);
    chk("num", 16'h0000, num);
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
    chk("ctrl", 16'h0040, 16'(ctrl));
    chk("polarity", 16'h0000, {13'h0, rev_pol});
    print_verdict();
  end
  initial begin
    #500000;
    fail_count++;
    print_verdict();
  end
endmodule
